// >>> ocm_side_path_defines.svh
`ifndef OCM_SIDE_PATH_DEFINES_SVH
`define OCM_SIDE_PATH_DEFINES_SVH

// control register bus widths
`define CRB_ADDR_W        10
`define CRB_DATA_W        32

// register indexes on the control register bus
`define REG_ISIDE_BASE    10'h000
`define REG_DSIDE_BASE    10'h001
`define REG_INIT_ADDR     10'h002
`define REG_FILL_DATA     10'h003
`define REG_CONTROL       10'h004

// control register fields
`define CTL_ISIDE_EN_BIT  0
`define CTL_DSIDE_EN_BIT  1
`define CTL_BUSY_BIT      2

// reset values
`define BASE_RESET        8'h00
`define INIT_RESET        22'h000000
`define CTL_RESET         2'h0

// base compare: big-endian bits 0:7 are the top byte
`define BASE_MSB          31
`define BASE_LSB          24
`define BASE_W            8

// memory address slices (big-endian bits 8:28 and 8:29)
`define ADDR_MSB          23
`define ISIDE_ADDR_LSB    3
`define DSIDE_ADDR_LSB    2
`define ISIDE_ADDR_W      21
`define DSIDE_ADDR_W      22

// indirect pointer: 64-bit word index plus odd/even select in bit 0
`define INIT_W            22
`define INIT_SEL_BIT      0

`endif

// >>> ocm_side_path_pkg.sv
`include "ocm_side_path_defines.svh"

package ocm_side_path_pkg;

  // control register bus access state
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_WAIT,
    ST_RD_CAPTURE,
    ST_ACK,
    ST_HOLD
  } access_state_t;

  // strobes, select and address toward the two fabric memory banks
  typedef struct packed {
    logic                       even_bank_enable;
    logic                       odd_bank_enable;
    logic                       even_bank_write_strobe;
    logic                       odd_bank_write_strobe;
    logic                       word_read_select;
    logic [`ISIDE_ADDR_W-1:0]   indirect_memory_address;
    logic [`CRB_DATA_W-1:0]     write_data;
  } bank_port_t;

endpackage

// >>> base_match_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "ocm_side_path_defines.svh"

// base compare for one memory side, registered hit and fabric address
module base_match_decode #(
  parameter int ADDR_W = 21, // address bits sent to fabric memory
  parameter int ADDR_LSB = 3 // lowest processor address bit used
) (
  input  wire logic              clk_in,    // core clock
  input  wire logic              rst_n_in,  // async reset, active low
  input  wire logic              ce_in,     // clock enable
  input  wire logic              enable_in, // side decoding enabled
  input  wire logic [`BASE_W-1:0] base_in,  // stored base byte
  input  wire logic [31:0]       addr_in,   // processor address
  output logic                   hit_out,   // access belongs here
  output logic [ADDR_W-1:0]      maddr_out  // address to fabric memory
);

  logic              hit_q;   // registered match
  logic [ADDR_W-1:0] maddr_q; // registered memory address

  // top byte against base picks one 16 MB region out of 4 GB
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hit_q <= 1'b0;
    end else if (ce_in) begin
      hit_q <= enable_in &&
               (addr_in[`BASE_MSB:`BASE_LSB] == base_in); // [R10] [R11]
    end
  end

  // only the bits below the base byte reach the fabric
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      maddr_q <= '0;
    end else if (ce_in) begin
      maddr_q <= addr_in[ADDR_LSB +: ADDR_W]; // [R12]
    end
  end

  assign hit_out   = hit_q;
  assign maddr_out = maddr_q;

  default clocking dcb @(posedge clk_in iff ce_in); endclocking
  default disable iff (!rst_n_in);

  chk_base_region_hit: assert property ( // [R10]
    hit_q == ($past(enable_in) &&
              $past(addr_in[`BASE_MSB:`BASE_LSB]) == $past(base_in)))
    else $error("base compare hit wrong");

  // the address is cleared during reset, so skip the edge after it
  chk_fabric_addr_slice: assert property ( // [R12]
    $past(rst_n_in) |-> maddr_q == $past(addr_in[`ADDR_MSB -: ADDR_W]))
    else $error("fabric address slice wrong");

endmodule
`default_nettype wire

// >>> ocm_side_path.sv
`timescale 1ns/1ps
`default_nettype none
`include "ocm_side_path_defines.svh"

// Functional notes
// R1 - even write strobe only on valid bus write
// R2 - odd enable qualifies each odd-word bus access
// R3 - even enable qualifies each even-word bus access
// R4 - fabric muxes 64-bit read data to 32
// R5 - read select high odd, low even
// R6 - older parts: strobe drives enable and write
// R7 - newer parts: strobe to write, enable to enable
// R8 - single-port memories may leave strobe open
// R9 - software reads and writes control registers
// R10 - eight-bit base compared with address bits 0:7
// R11 - each memory in its own 16 MB region
// R12 - at most 22 address bits to fabric
// R13 - odd write strobe only on valid bus write
// R14 - indirect address loaded from initial address register
// R15 - one-cycle strobes, banks mutually exclusive
module ocm_side_path
  import ocm_side_path_pkg::*;
(
  input  wire logic                     CORE_CLK_IN,  // 200 MHz core clock
  input  wire logic                     RESETN_IN,    // async reset, low
  input  wire logic                     CE_IN,        // clock enable
  input  wire logic [`CRB_ADDR_W-1:0]   CRB_ADDR_IN,  // register index
  input  wire logic                     CRB_READ_IN,  // read request
  input  wire logic                     CRB_WRITE_IN, // write request
  input  wire logic [`CRB_DATA_W-1:0]   CRB_WDATA_IN, // write data
  output logic [`CRB_DATA_W-1:0]        CRB_RDATA_OUT,// read data
  output logic                          CRB_ACK_OUT,  // access done
  input  wire logic [`CRB_DATA_W-1:0]   MEM_RDATA_IN, // muxed bank data
  output bank_port_t                    BANK_OUT,     // bank port bundle
  input  wire logic [31:0]              IFETCH_ADDR_IN, // fetch address
  input  wire logic [31:0]              DLOAD_ADDR_IN,  // data address
  output logic                          ISIDE_HIT_OUT,  // fetch hit
  output logic [`ISIDE_ADDR_W-1:0]      ISIDE_MADDR_OUT,// fetch address
  output logic                          DSIDE_HIT_OUT,  // data hit
  output logic [`DSIDE_ADDR_W-1:0]      DSIDE_MADDR_OUT // data address
);

  access_state_t          state_q;  // bus access state
  access_state_t          state_d;  // next state
  logic [`BASE_W-1:0]     ibase_q;  // instr_side_base_address
  logic [`BASE_W-1:0]     dbase_q;  // data_side_base_address
  logic [`INIT_W-1:0]     init_q;   // initial_address_register
  logic [1:0]             ctl_q;    // side enables
  logic [`CRB_DATA_W-1:0] rdata_q;  // bus read data
  bank_port_t             bank_q;   // registered bank port
  logic                   take;     // new request accepted this cycle
  logic                   fill_wr;  // accepted write to fill data
  logic                   fill_rd;  // accepted read of fill data
  logic                   reg_wr;   // accepted write to plain register

  // register index decode, used for both access kinds
  function automatic logic is_reg(input logic [`CRB_ADDR_W-1:0] a,
                                  input logic [`CRB_ADDR_W-1:0] r);
    is_reg = (a == r);
  endfunction

  // requests are level; only idle takes one so a held level is not reused
  assign take    = (state_q == ST_IDLE) && (CRB_READ_IN || CRB_WRITE_IN);
  assign fill_wr = take && CRB_WRITE_IN &&
                   is_reg(CRB_ADDR_IN, `REG_FILL_DATA);
  assign fill_rd = take && !CRB_WRITE_IN &&
                   is_reg(CRB_ADDR_IN, `REG_FILL_DATA);
  assign reg_wr  = take && CRB_WRITE_IN && !fill_wr;

  // next-state logic: reads of memory wait for the synchronous bank
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (fill_rd) begin
          state_d = ST_RD_WAIT;
        end else if (take) begin
          state_d = ST_ACK;
        end
      end
      ST_RD_WAIT:    state_d = ST_RD_CAPTURE;
      ST_RD_CAPTURE: state_d = ST_ACK;
      ST_ACK:        state_d = ST_HOLD;
      ST_HOLD: begin
        // wait for the requester to drop its level
        if (!CRB_READ_IN && !CRB_WRITE_IN) begin
          state_d = ST_IDLE;
        end
      end
      default:       state_d = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_q <= ST_IDLE;
    end else if (CE_IN) begin
      state_q <= state_d;
    end
  end

  // software-visible registers, written over the control register bus
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ibase_q <= `BASE_RESET;
      dbase_q <= `BASE_RESET;
      init_q  <= `INIT_RESET;
      ctl_q   <= `CTL_RESET;
    end else if (CE_IN && reg_wr) begin // [R9]
      if (is_reg(CRB_ADDR_IN, `REG_ISIDE_BASE)) begin
        ibase_q <= CRB_WDATA_IN[`BASE_W-1:0]; // [R10]
      end
      if (is_reg(CRB_ADDR_IN, `REG_DSIDE_BASE)) begin
        dbase_q <= CRB_WDATA_IN[`BASE_W-1:0]; // [R10]
      end
      if (is_reg(CRB_ADDR_IN, `REG_INIT_ADDR)) begin
        init_q  <= CRB_WDATA_IN[`INIT_W-1:0];
      end
      if (is_reg(CRB_ADDR_IN, `REG_CONTROL)) begin
        ctl_q   <= CRB_WDATA_IN[`CTL_DSIDE_EN_BIT:`CTL_ISIDE_EN_BIT];
      end
    end
  end

  // read data: registers answer at once, memory after the bank latency
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rdata_q <= '0;
    end else if (CE_IN) begin
      if (state_q == ST_RD_CAPTURE) begin
        rdata_q <= MEM_RDATA_IN; // fabric already picked the word [R4]
      end else if (take && !CRB_WRITE_IN && !fill_rd) begin // [R9]
        rdata_q <= '0; // unmapped indexes read zero
        if (is_reg(CRB_ADDR_IN, `REG_ISIDE_BASE)) begin
          rdata_q[`BASE_W-1:0] <= ibase_q;
        end
        if (is_reg(CRB_ADDR_IN, `REG_DSIDE_BASE)) begin
          rdata_q[`BASE_W-1:0] <= dbase_q;
        end
        if (is_reg(CRB_ADDR_IN, `REG_INIT_ADDR)) begin
          rdata_q[`INIT_W-1:0] <= init_q;
        end
        if (is_reg(CRB_ADDR_IN, `REG_CONTROL)) begin
          rdata_q[`CTL_DSIDE_EN_BIT:`CTL_ISIDE_EN_BIT] <= ctl_q;
          rdata_q[`CTL_BUSY_BIT] <= 1'b1; // an access is in flight now
        end
      end
    end
  end

  // bank strobes: one-cycle pulses, bank chosen by the pointer's low bit
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      bank_q <= '0;
    end else if (CE_IN) begin
      bank_q.even_bank_enable       <= (fill_wr || fill_rd) &&
                                       !init_q[`INIT_SEL_BIT]; // [R3] [R15]
      bank_q.odd_bank_enable        <= (fill_wr || fill_rd) &&
                                       init_q[`INIT_SEL_BIT]; // [R2] [R15]
      bank_q.even_bank_write_strobe <= fill_wr &&
                                       !init_q[`INIT_SEL_BIT]; // [R1]
      bank_q.odd_bank_write_strobe  <= fill_wr &&
                                       init_q[`INIT_SEL_BIT]; // [R13]
      // select holds between accesses so the mux stays stable
      bank_q.word_read_select <= init_q[`INIT_SEL_BIT]; // [R5]
      // address follows the stored pointer ahead of any access
      bank_q.indirect_memory_address <=
        init_q[`INIT_W-1:`INIT_SEL_BIT+1]; // [R14] [R12]
      if (fill_wr) begin
        bank_q.write_data <= CRB_WDATA_IN; // shared by both banks
      end
    end
  end

  assign BANK_OUT      = bank_q;
  assign CRB_RDATA_OUT = rdata_q;
  assign CRB_ACK_OUT   = (state_q == ST_ACK); // [R9]

  // instruction side: 21 bits to fabric
  base_match_decode #(
    .ADDR_W   (`ISIDE_ADDR_W),
    .ADDR_LSB (`ISIDE_ADDR_LSB)
  ) u_iside_decode (
    .clk_in    (CORE_CLK_IN),
    .rst_n_in  (RESETN_IN),
    .ce_in     (CE_IN),
    .enable_in (ctl_q[`CTL_ISIDE_EN_BIT]),
    .base_in   (ibase_q),
    .addr_in   (IFETCH_ADDR_IN),
    .hit_out   (ISIDE_HIT_OUT),
    .maddr_out (ISIDE_MADDR_OUT)
  );

  // data side: 22 bits to fabric, region independent of the other [R11]
  base_match_decode #(
    .ADDR_W   (`DSIDE_ADDR_W),
    .ADDR_LSB (`DSIDE_ADDR_LSB)
  ) u_dside_decode (
    .clk_in    (CORE_CLK_IN),
    .rst_n_in  (RESETN_IN),
    .ce_in     (CE_IN),
    .enable_in (ctl_q[`CTL_DSIDE_EN_BIT]),
    .base_in   (dbase_q),
    .addr_in   (DLOAD_ADDR_IN),
    .hit_out   (DSIDE_HIT_OUT),
    .maddr_out (DSIDE_MADDR_OUT)
  );

  // checks count only enabled clock edges
  default clocking mcb @(posedge CORE_CLK_IN iff CE_IN); endclocking
  default disable iff (!RESETN_IN);

  chk_even_write_cause: assert property ( // [R1]
    bank_q.even_bank_write_strobe |->
      $past(fill_wr) && !$past(init_q[`INIT_SEL_BIT]))
    else $error("even write strobe without bus write");

  chk_odd_write_cause: assert property ( // [R13]
    bank_q.odd_bank_write_strobe |->
      $past(fill_wr) && $past(init_q[`INIT_SEL_BIT]))
    else $error("odd write strobe without bus write");

  chk_odd_enable_access: assert property ( // [R2]
    (fill_wr || fill_rd) && init_q[`INIT_SEL_BIT] |=>
      bank_q.odd_bank_enable)
    else $error("odd enable missing on odd access");

  chk_even_enable_access: assert property ( // [R3]
    (fill_wr || fill_rd) && !init_q[`INIT_SEL_BIT] |=>
      bank_q.even_bank_enable && !bank_q.odd_bank_enable)
    else $error("even enable missing on even access");

  chk_read_select_level: assert property ( // [R5]
    bank_q.even_bank_enable || bank_q.odd_bank_enable |->
      bank_q.word_read_select == bank_q.odd_bank_enable)
    else $error("read select disagrees with bank");

  chk_mem_read_ack: assert property ( // [R9]
    fill_rd |-> ##3 CRB_ACK_OUT && rdata_q == $past(MEM_RDATA_IN))
    else $error("memory read not answered in three cycles");

  chk_reg_ack_time: assert property ( // [R9]
    take && !fill_rd |=> CRB_ACK_OUT ##1 !CRB_ACK_OUT)
    else $error("register access ack timing wrong");

  chk_addr_from_init: assert property ( // [R14]
    bank_q.even_bank_enable || bank_q.odd_bank_enable |->
      bank_q.indirect_memory_address ==
        $past(init_q[`INIT_W-1:`INIT_SEL_BIT+1]))
    else $error("indirect address not from pointer");

  chk_strobe_one_cycle: assert property ( // [R15]
    (bank_q.even_bank_enable || bank_q.odd_bank_enable) |=>
      !bank_q.even_bank_enable && !bank_q.odd_bank_enable)
    else $error("bank strobe longer than one cycle");

  // a fill write strobes the bank in the same cycle as its ack
  cov_even_write: cover property (
    bank_q.even_bank_write_strobe && CRB_ACK_OUT);
  cov_odd_write: cover property (
    bank_q.odd_bank_write_strobe && CRB_ACK_OUT);
  cov_mem_read: cover property (fill_rd ##3 CRB_ACK_OUT);
  cov_both_hits: cover property (ISIDE_HIT_OUT && DSIDE_HIT_OUT);

endmodule
`default_nettype wire

// >>> bank_pair_model.sv
`timescale 1ns/1ps
`default_nettype none

// two 32-bit fabric banks, synchronous read, fabric word mux on read data
module bank_pair_model
  import ocm_side_path_pkg::*;
#(
  parameter bit OLDER_WIRING = 1'b0, // write strobe is the enable too
  parameter bit WRITES_WIRED = 1'b1  // 0: single-port, strobes open
) (
  input  wire logic        clk_in,    // core clock
  input  wire bank_port_t  bank_in,   // strobes, address and data
  output logic [31:0]      rdata_out  // muxed word back to controller
);
  logic [31:0] even_mem [0:15]; // even words, small depth is enough here
  logic [31:0] odd_mem  [0:15]; // odd words
  logic [31:0] even_q;          // even bank output register
  logic [31:0] odd_q;           // odd bank output register
  logic [31:0] last_q;          // last value seen on the data lines
  logic        sel_q;           // select as it stood at the read
  logic        vld_q;           // data lines carry a real read
  logic [3:0]  a;               // low word index
  logic        even_en;         // even port enable as wired
  logic        odd_en;          // odd port enable as wired

  assign a = bank_in.indirect_memory_address[3:0];

  // older wiring: the write strobe drives the port enable as well
  assign even_en = OLDER_WIRING ? bank_in.even_bank_write_strobe
                                : bank_in.even_bank_enable;
  assign odd_en  = OLDER_WIRING ? bank_in.odd_bank_write_strobe
                                : bank_in.odd_bank_enable;

  // enable is the port enable, write strobe the port write enable
  // a single-port build leaves the strobes open and never writes
  always_ff @(posedge clk_in) begin
    if (even_en) begin
      if (WRITES_WIRED && bank_in.even_bank_write_strobe) begin
        even_mem[a] <= bank_in.write_data;
      end
      even_q <= even_mem[a];
    end
    if (odd_en) begin
      if (WRITES_WIRED && bank_in.odd_bank_write_strobe) begin
        odd_mem[a] <= bank_in.write_data;
      end
      odd_q <= odd_mem[a];
    end
    vld_q  <= even_en | odd_en;
    sel_q  <= bank_in.word_read_select;
    last_q <= rdata_out;
  end

  // word mux; outside a read the lines flip so stale data never matches
  assign rdata_out = vld_q ? (sel_q ? odd_q : even_q) : ~last_q;
endmodule
`default_nettype wire

// >>> tb_ocm_side_path.sv
`timescale 1ns/1ps
`default_nettype none

module tb_ocm_side_path;
  import ocm_side_path_pkg::*;
  logic        clk, rst_n, rd, wr;   // clock, reset, requests
  logic        ce;                   // clock enable
  logic [9:0]  adr;                  // register index
  logic [31:0] wd, rdat, mrd, q;     // bus data, bank data, scratch
  logic        ack, ihit, dhit;      // answers
  logic [20:0] imad;                 // fetch address to fabric
  logic [21:0] dmad;                 // data address to fabric
  logic [31:0] ifa, dla;             // processor addresses
  bank_port_t  bank, snap;           // bank port and its ack-cycle copy
  int          fails, num_checks;    // counters

  ocm_side_path ocm_side_path_i (.CORE_CLK_IN(clk), .RESETN_IN(rst_n),
    .CE_IN(ce), .CRB_ADDR_IN(adr), .CRB_READ_IN(rd), .CRB_WRITE_IN(wr),
    .CRB_WDATA_IN(wd), .CRB_RDATA_OUT(rdat), .CRB_ACK_OUT(ack),
    .MEM_RDATA_IN(mrd), .BANK_OUT(bank), .IFETCH_ADDR_IN(ifa),
    .DLOAD_ADDR_IN(dla), .ISIDE_HIT_OUT(ihit), .ISIDE_MADDR_OUT(imad),
    .DSIDE_HIT_OUT(dhit), .DSIDE_MADDR_OUT(dmad));
  bank_pair_model bank_pair_model_i (.clk_in(clk), .bank_in(bank),
    .rdata_out(mrd));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus access: hold request until ack, copy bank port at ack
  task automatic crb(input logic w, input logic [9:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    for (n = 0; n < 10; n++) begin
      @(posedge clk);
      #1;
      if (ack === 1'b1) break;
    end
    if (n == 10) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, 0, 1);
      give_verdict();
    end
    r = rdat;
    snap = bank;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // stray both-bank write strobes are never allowed
  always @(posedge clk) begin
    if (bank.even_bank_write_strobe && bank.odd_bank_write_strobe)
      chk(1'b1, 1'b0);
  end

  // reset values, control busy bit, unmapped index
  task automatic t_reset();
    crb(0, 10'h000, 0, q);
    chk(q, 32'h0);
    crb(0, 10'h001, 0, q);
    chk(q, 32'h0);
    crb(0, 10'h002, 0, q);
    chk(q, 32'h0);
    crb(0, 10'h004, 0, q);
    chk(q, 32'h4);
    crb(1, 10'h3ff, 32'hffffffff, q);
    crb(0, 10'h3ff, 0, q);
    chk(q, 32'h0);
    $display("test reset done");
  endtask

  // base registers and both address decoders
  task automatic t_decode();
    crb(1, 10'h000, 32'h12, q);
    crb(1, 10'h001, 32'hab, q);
    crb(0, 10'h000, 0, q);
    chk(q, 32'h12);
    crb(0, 10'h001, 0, q);
    chk(q, 32'hab);
    ifa <= 32'h12345678;
    dla <= 32'hab9abcde;
    repeat (2) @(posedge clk);
    #1 chk(ihit, 1'b0);
    crb(1, 10'h004, 32'h3, q);
    crb(0, 10'h004, 0, q);
    chk(q, 32'h7);
    #1 chk(ihit, 1'b1);
    chk(dhit, 1'b1);
    chk(imad, 21'h068acf);
    chk(dmad, 22'h26af37);
    @(posedge clk);
    ifa <= 32'h13345678;
    dla <= 32'haaffffff;
    repeat (2) @(posedge clk);
    #1 chk(ihit, 1'b0);
    chk(dhit, 1'b0);
    $display("test decode done");
  endtask

  // fill writes to both banks, then read back through the word mux
  task automatic t_fill();
    logic [21:0] p;
    for (int i = 0; i < 4; i++) begin
      p = 22'(i + 4);
      crb(1, 10'h002, 32'(p), q);
      #1 chk(bank.indirect_memory_address, 21'(p >> 1));
      chk(bank.word_read_select, p[0]);
      crb(1, 10'h003, 32'hc0de0000 + i, q);
      chk(snap.even_bank_write_strobe, !p[0]);
      chk(snap.odd_bank_write_strobe, p[0]);
      chk(snap.even_bank_enable, !p[0]);
      chk(snap.odd_bank_enable, p[0]);
      chk(snap.write_data, 32'hc0de0000 + i);
      #1 chk(bank.even_bank_write_strobe |
             bank.odd_bank_write_strobe, 1'b0);
    end
    for (int i = 3; i >= 0; i--) begin
      p = 22'(i + 4);
      crb(1, 10'h002, 32'(p), q);
      crb(0, 10'h003, 0, q);
      chk(q, 32'hc0de0000 + i);
      chk(snap.even_bank_write_strobe |
          snap.odd_bank_write_strobe, 1'b0);
    end
    $display("test fill done");
  endtask

  // clock enable low freezes the bus state machine and the instruction-side decoder
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    wr <= 1'b1;
    adr <= 10'h000;
    wd <= 32'h34;
    ifa <= 32'h12000008;
    repeat (3) @(posedge clk);
    #1 chk(ihit, 1'b0);
    chk(ack, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(ihit, 1'b1);
    chk(imad, 21'h000001);
    crb(0, 10'h000, 0, q);
    chk(q, 32'h12);
    $display("test freeze done");
  endtask

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = '0;
    wd = '0;
    ifa = '0;
    dla = '0;
    fails = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_decode();
    t_fill();
    t_freeze();
    give_verdict();
  end
endmodule
`default_nettype wire
